// ==== src/sbcm_pkg.sv ====
// Purpose: Shared constants for the standby / colour-mode command link.
// Assumes: 50 MHz pclk, 16-bit link words, APB with 32-bit data.
// Notes:   Index codes, field positions, reset values, timing and APB map.
package sbcm_pkg;
  // ==========================================================================
  // Link register indexes
  localparam logic [6:0] IDX_CTL = 7'h00;  // display_control_one
  localparam logic [6:0] IDX_COL = 7'h06;  // column_address
  localparam logic [6:0] IDX_ROW = 7'h07;  // row_address
  localparam logic [6:0] IDX_PIX = 7'h0C;  // pixel_memory_port
  localparam logic [6:0] IDX_PWR = 7'h19;  // power_enable_control
  // ==========================================================================
  // Control register fields
  localparam int CTL_WHITE = 7;
  localparam int CTL_BLACK = 6;
  localparam int CTL_APP   = 5;
  localparam int CTL_PART  = 4;
  localparam int CTL_STANDBY_REQUEST  = 3;
  localparam int CTL_COL8  = 2;
  localparam int CTL_PMODE = 1;
  // Power enable fields
  localparam int PWR_GATE  = 2;
  localparam int PWR_PIC   = 1;
  localparam int PWR_DCDC  = 0;
  localparam int PWR_APP_LO = 3;
  // Pixel dot MSBs
  localparam int DOT1_MSB = 15;
  localparam int DOT2_MSB = 10;
  localparam int DOT3_MSB = 4;
  // Reset values
  localparam logic [6:0] RST_INDEX = 7'h00;
  localparam logic [7:0] RST_REG8  = 8'h00;
  // ==========================================================================
  // Geometry and timing
  localparam int DEF_COLS      = 132;
  localparam int DEF_ROWS      = 176;
  localparam int CLK_NS        = 20;
  localparam int DCDC_WAIT_NS  = 50_000_000;
  localparam int REG_WAIT_NS   = 20_000_000;
  localparam int GATE_WAIT_NS  = 1_000_000;
  localparam int OFF_WAIT_NS   = 0;
  localparam int DCDC_WAIT_CYC = (DCDC_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int REG_WAIT_CYC  = (REG_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int GATE_WAIT_CYC = (GATE_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int OFF_WAIT_CYC  = (OFF_WAIT_NS == 0) ? 1 : (OFF_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_CYC     = DEF_COLS * DEF_ROWS + 2;
  // ==========================================================================
  // Host command opcodes and APB map
  localparam logic [2:0] OP_IDX   = 3'h0;
  localparam logic [2:0] OP_DATA  = 3'h1;
  localparam logic [2:0] OP_SON   = 3'h2;
  localparam logic [2:0] OP_SOFF  = 3'h3;
  localparam logic [2:0] OP_BLANK = 3'h4;
  localparam logic [2:0] OP_DONE  = 3'h5;
  localparam logic [7:0] A_CMD  = 8'h00;
  localparam logic [7:0] A_ARG  = 8'h04;
  localparam logic [7:0] A_CFG  = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam int CFG_SKIPG = 5;
  localparam int CFG_PMODE = 6;
  localparam int CFG_COL8  = 7;
endpackage

// ==== src/sbcm_link_if.sv ====
// Purpose: Write-only command link between host end and device end.
// Assumes: Both ends on pclk; one word per cycle with wr high.
// Notes:   rs low selects the index pointer, high the indexed register.
`timescale 1ns/1ns
`default_nettype none
interface sbcm_link_if;
  logic        wr;
  logic        rs;
  logic [15:0] wd;
  modport host (output wr, rs, wd);
  modport dev  (input wr, rs, wd);
endinterface
`default_nettype wire

// ==== src/sbcm_dev.sv ====
// Purpose: Device end: registers, pixel memory, scan, standby, colour mode.
// Assumes: Link words synchronous to pclk; host keeps its own timing.
// Notes:   Pixel memory is an array beside the state struct.
`timescale 1ns/1ns
`default_nettype none
module sbcm_dev #(
  parameter int COLS = sbcm_pkg::DEF_COLS,
  parameter int ROWS = sbcm_pkg::DEF_ROWS
) (
  input  wire logic  pclk,
  input  wire logic  presetn,
  sbcm_link_if.dev   link,
  output logic [1:0]  src_level,
  output logic [15:0] pix_out,
  output logic        gate_all_on,
  output logic        osc_amp_on,
  output logic        color8,
  output logic        partial,
  output logic        power_mode,
  output logic        gate_reg_en,
  output logic        pic_reg_en,
  output logic        dcdc_en
);
  // ==========================================================================
  // Types and state
  typedef enum logic [2:0] {RUN = 3'b001, DRAIN = 3'b010, HALT = 3'b100} sb_t;
  typedef struct packed {
    sb_t         sb;
    logic [6:0]  index;
    logic [7:0]  ctl;
    logic [7:0]  pwr;
    logic [7:0]  colx;
    logic [7:0]  rowy;
    logic [7:0]  sx;
    logic [7:0]  sy;
    logic [1:0]  src;
    logic [15:0] pix;
  } ds_t;
  localparam logic [1:0] SRC_NORM = 2'h0, SRC_WHITE = 2'h1, SRC_BLACK = 2'h2, SRC_GND = 2'h3;
  localparam logic [7:0] XMAX = 8'(COLS - 1);
  localparam logic [7:0] YMAX = 8'(ROWS - 1);

  ds_t q, d;
  logic [15:0] ram [COLS*ROWS];

  function automatic int addr_fn(input logic [7:0] x, input logic [7:0] y);
    return int'(y) * COLS + int'(x);
  endfunction

  // Only the dot MSBs count; each dot swings rail to rail
  function automatic logic [15:0] dots8(input logic [15:0] w);
    return {{5{w[sbcm_pkg::DOT1_MSB]}}, {6{w[sbcm_pkg::DOT2_MSB]}}, {5{w[sbcm_pkg::DOT3_MSB]}}};
  endfunction

  logic wr_reg, wr_pix, frame_end;
  assign wr_reg    = link.wr && link.rs;
  assign wr_pix    = wr_reg && (q.index == sbcm_pkg::IDX_PIX);
  assign frame_end = (q.sx == XMAX) && (q.sy == YMAX);

  // ==========================================================================
  // Next state
  always_comb begin
    logic [15:0] w;
    w = 16'h0000;
    d = q;
    // Index load on rs low, register store on rs high
    if (link.wr && !link.rs) begin
      d.index = link.wd[6:0];
    end
    if (wr_reg) begin
      unique case (q.index)
        sbcm_pkg::IDX_CTL: d.ctl  = link.wd[7:0];
        sbcm_pkg::IDX_PWR: d.pwr  = link.wd[7:0];
        sbcm_pkg::IDX_COL: d.colx = link.wd[7:0];
        sbcm_pkg::IDX_ROW: d.rowy = link.wd[7:0];
        default: ;
      endcase
    end
    // Pixel writes step X, then wrap onto the next row
    if (wr_pix) begin
      d.colx = (q.colx >= XMAX) ? 8'h00 : q.colx + 8'h01;
      if (q.colx >= XMAX) begin
        d.rowy = (q.rowy >= YMAX) ? 8'h00 : q.rowy + 8'h01;
      end
    end
    // Standby: finish the frame, then park
    unique case (q.sb)
      RUN:     if (q.ctl[sbcm_pkg::CTL_STANDBY_REQUEST]) d.sb = DRAIN;
      DRAIN: begin
        if (!q.ctl[sbcm_pkg::CTL_STANDBY_REQUEST]) d.sb = RUN;
        else if (frame_end) d.sb = HALT;
      end
      HALT:    if (!q.ctl[sbcm_pkg::CTL_STANDBY_REQUEST]) d.sb = RUN;
    endcase
    // Scan runs only while the oscillator runs
    if (q.sb != HALT) begin
      d.sx = (q.sx == XMAX) ? 8'h00 : q.sx + 8'h01;
      if (q.sx == XMAX) d.sy = (q.sy == YMAX) ? 8'h00 : q.sy + 8'h01;
    end else begin
      d.sx = 8'h00;
      d.sy = 8'h00;
    end
    // Ground overrides both display overrides; next standby state keeps release to two edges
    if (q.ctl[sbcm_pkg::CTL_STANDBY_REQUEST] || d.sb != RUN) d.src = SRC_GND;
    else if (q.ctl[sbcm_pkg::CTL_WHITE]) d.src = SRC_WHITE;
    else if (q.ctl[sbcm_pkg::CTL_BLACK]) d.src = SRC_BLACK;
    else d.src = SRC_NORM;
    w = ram[addr_fn(q.sx, q.sy)];
    if (d.src == SRC_WHITE) d.pix = 16'hFFFF;
    else if (d.src != SRC_NORM) d.pix = 16'h0000;
    else if (q.ctl[sbcm_pkg::CTL_COL8]) d.pix = dots8(w);
    else d.pix = w;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{sb: RUN, index: sbcm_pkg::RST_INDEX, ctl: sbcm_pkg::RST_REG8, pwr: sbcm_pkg::RST_REG8,
             colx: 8'h00, rowy: 8'h00, sx: 8'h00, sy: 8'h00, src: 2'h0, pix: 16'h0000};
    end else begin
      q <= d;
    end
  end

  // Memory keeps its contents across reset
  always_ff @(posedge pclk) begin
    if (wr_pix) begin
      ram[addr_fn(q.colx, q.rowy)] <= link.wd;
    end
  end

  assign src_level   = q.src;
  assign pix_out     = q.pix;
  assign gate_all_on = (q.sb == HALT);
  assign osc_amp_on  = (q.sb != HALT);
  assign color8      = q.ctl[sbcm_pkg::CTL_COL8];
  assign partial     = q.ctl[sbcm_pkg::CTL_PART];
  assign power_mode  = q.ctl[sbcm_pkg::CTL_PMODE];
  assign gate_reg_en = q.pwr[sbcm_pkg::PWR_GATE];
  assign pic_reg_en  = q.pwr[sbcm_pkg::PWR_PIC];
  assign dcdc_en     = q.pwr[sbcm_pkg::PWR_DCDC];
endmodule
`default_nettype wire

// ==== src/sbcm_host.sv ====
// Purpose: Host end: APB-driven sequencer issuing link command words.
// Assumes: Zero-wait link; device applies each word on the edge it sees wr.
// Notes:   One command at a time; commands while busy are dropped.
//
// Overview of operation
// - Standby grounds sources, drains frame, then halts.
// - Standby ground overrides white and black bits.
// - Control register bit layout white/black/partial/standby/colour/power.
// - Wait one frame after standby before power.
// - Power register drives gate, regulator, converter enables.
// - Standby entry clears gate enable only, then waits.
// - Gate enable step may be skipped.
// - Release first clears standby with white output.
// - Then enable converter only, wait about 50 ms.
// - Then add power regulator, wait about 20 ms.
// - Then add gate regulator, wait about 1 ms.
// - Display on only after all supplies enabled.
// - Colour bit selects 8-colour versus full colour.
// - 8-colour uses dot MSBs bits 15, 10, 4.
// - 8-colour drives sources rail to rail.
// - Mode change requires rewriting the pixel memory.
// - Blank black before the rewrite.
// - After rewrite set colour bit, clear black.
// - Leaving 8-colour, blank in old mode first.
// - One 16-bit word per pixel, three dots.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module sbcm_host #(
  parameter int FRAME_WAIT = sbcm_pkg::FRAME_CYC,
  parameter int OFF_WAIT   = sbcm_pkg::OFF_WAIT_CYC,
  parameter int DCDC_WAIT  = sbcm_pkg::DCDC_WAIT_CYC,
  parameter int REG_WAIT   = sbcm_pkg::REG_WAIT_CYC,
  parameter int GATE_WAIT  = sbcm_pkg::GATE_WAIT_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  sbcm_link_if.host   link
);
  // ==========================================================================
  // Types
  typedef enum logic [2:0] {S_IDLE = 3'b001, S_SEND = 3'b010, S_WAIT = 3'b100} st_t;
  typedef enum logic [1:0] {K_END = 2'h0, K_WR = 2'h1, K_SKIP = 2'h2} kind_t;
  typedef enum logic [2:0] {W_NONE, W_FRAME, W_OFF, W_DCDC, W_REG, W_GATE} wsel_t;
  typedef struct packed {
    kind_t       kind;
    logic        rs;
    logic [15:0] data;
    wsel_t       wsel;
  } step_t;
  typedef struct packed {
    st_t         st;
    logic [2:0]  op;
    logic [3:0]  step;
    logic [31:0] cnt;
    logic [15:0] arg;
    logic [7:0]  cfg;
    logic        col8;
    logic        rdy;
    logic        err;
    logic [31:0] rdata;
    logic        wr;
    logic        rs;
    logic [15:0] wd;
  } hs_t;

  hs_t q, d;

  // ==========================================================================
  // Word builders
  function automatic logic [15:0] ctl_fn(input logic white, input logic black, input logic standby_request,
                                         input logic col8, input logic [7:0] cfg);
    logic [15:0] v;
    v = 16'h0000;
    v[sbcm_pkg::CTL_WHITE] = white;
    v[sbcm_pkg::CTL_BLACK] = black;
    v[sbcm_pkg::CTL_APP]   = cfg[4];
    v[sbcm_pkg::CTL_STANDBY_REQUEST]  = standby_request;
    v[sbcm_pkg::CTL_COL8]  = col8;
    v[sbcm_pkg::CTL_PMODE] = cfg[sbcm_pkg::CFG_PMODE];
    return v;
  endfunction

  function automatic logic [15:0] pwr_fn(input logic g, input logic p, input logic c,
                                         input logic [7:0] cfg);
    logic [15:0] v;
    v = 16'h0000;
    v[sbcm_pkg::PWR_APP_LO +: 4] = cfg[3:0];
    v[sbcm_pkg::PWR_GATE] = g;
    v[sbcm_pkg::PWR_PIC]  = p;
    v[sbcm_pkg::PWR_DCDC] = c;
    return v;
  endfunction

  function automatic step_t ix(input logic [6:0] i);
    return '{kind: K_WR, rs: 1'b0, data: {9'h000, i}, wsel: W_NONE};
  endfunction

  function automatic step_t dt(input logic [15:0] v, input wsel_t w);
    return '{kind: K_WR, rs: 1'b1, data: v, wsel: w};
  endfunction

  // ==========================================================================
  // Command sequences, one step per link word
  function automatic step_t step_fn(input hs_t s);
    step_t r;
    logic  sk;
    r  = '{kind: K_END, rs: 1'b0, data: 16'h0000, wsel: W_NONE};
    sk = s.cfg[sbcm_pkg::CFG_SKIPG];
    unique case (s.op)
      sbcm_pkg::OP_IDX:  if (s.step == 4'd0) r = ix(s.arg[6:0]);
      sbcm_pkg::OP_DATA: if (s.step == 4'd0) r = dt(s.arg, W_NONE);
      sbcm_pkg::OP_SON: begin
        unique case (s.step)
          4'd0: r = ix(sbcm_pkg::IDX_CTL);
          4'd1: r = dt(ctl_fn(1'b0, 1'b0, 1'b1, s.col8, s.cfg), W_FRAME);
          4'd2: if (!sk) r = ix(sbcm_pkg::IDX_PWR);
          4'd3: if (!sk) r = dt(pwr_fn(1'b0, 1'b1, 1'b1, s.cfg), W_OFF);
          default: ;
        endcase
      end
      sbcm_pkg::OP_SOFF: begin
        unique case (s.step)
          4'd0: r = ix(sbcm_pkg::IDX_CTL);
          4'd1: r = dt(ctl_fn(1'b1, 1'b0, 1'b0, s.col8, s.cfg), W_NONE);
          4'd2: r = ix(sbcm_pkg::IDX_PWR);
          4'd3: r = dt(pwr_fn(1'b0, 1'b0, 1'b1, s.cfg), W_DCDC);
          4'd4: r = ix(sbcm_pkg::IDX_PWR);
          4'd5: r = dt(pwr_fn(1'b0, 1'b1, 1'b1, s.cfg), W_REG);
          4'd6: r = sk ? '{kind: K_SKIP, rs: 1'b0, data: 16'h0000, wsel: W_NONE}
                       : ix(sbcm_pkg::IDX_PWR);
          4'd7: r = sk ? '{kind: K_SKIP, rs: 1'b0, data: 16'h0000, wsel: W_NONE}
                       : dt(pwr_fn(1'b1, 1'b1, 1'b1, s.cfg), W_GATE);
          4'd8: r = ix(sbcm_pkg::IDX_CTL);
          4'd9: r = dt(ctl_fn(1'b0, 1'b0, 1'b0, s.col8, s.cfg), W_NONE);
          default: ;
        endcase
      end
      sbcm_pkg::OP_BLANK: begin
        unique case (s.step)
          4'd0: r = ix(sbcm_pkg::IDX_CTL);
          4'd1: r = dt(ctl_fn(1'b0, 1'b1, 1'b0, s.col8, s.cfg), W_NONE);
          4'd2: r = ix(sbcm_pkg::IDX_COL);
          4'd3: r = dt(16'h0000, W_NONE);
          4'd4: r = ix(sbcm_pkg::IDX_ROW);
          4'd5: r = dt(16'h0000, W_NONE);
          4'd6: r = ix(sbcm_pkg::IDX_PIX);
          default: ;
        endcase
      end
      sbcm_pkg::OP_DONE: begin
        unique case (s.step)
          4'd0: r = ix(sbcm_pkg::IDX_CTL);
          4'd1: r = dt(ctl_fn(1'b0, 1'b0, 1'b0, s.cfg[sbcm_pkg::CFG_COL8], s.cfg), W_NONE);
          default: ;
        endcase
      end
      default: ;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] wait_fn(input wsel_t w);
    unique case (w)
      W_FRAME: return 32'(FRAME_WAIT);
      W_OFF:   return 32'(OFF_WAIT);
      W_DCDC:  return 32'(DCDC_WAIT);
      W_REG:   return 32'(REG_WAIT);
      W_GATE:  return 32'(GATE_WAIT);
      default: return 32'h0000_0001;
    endcase
  endfunction

  // ==========================================================================
  // Next state: APB slave and sequencer
  always_comb begin
    step_t s;
    logic  acc, done;
    s    = step_fn(q);
    acc  = psel && penable;
    done = acc && q.rdy;
    d    = q;
    d.wr = 1'b0;
    d.err = 1'b0;
    // One wait cycle in the access phase; answer is registered
    d.rdy = acc && !q.rdy;
    if (acc && !q.rdy) begin
      d.err   = !(paddr inside {sbcm_pkg::A_CMD, sbcm_pkg::A_ARG, sbcm_pkg::A_CFG, sbcm_pkg::A_STAT});
      d.rdata = 32'h0000_0000;
      unique case (paddr)
        sbcm_pkg::A_CMD:  d.rdata = {29'h0, q.op};
        sbcm_pkg::A_ARG:  d.rdata = {16'h0, q.arg};
        sbcm_pkg::A_CFG:  d.rdata = {24'h0, q.cfg};
        sbcm_pkg::A_STAT: d.rdata = {26'h0, q.step, q.col8, q.st != S_IDLE};
        default: ;
      endcase
    end
    if (done && pwrite) begin
      if (paddr == sbcm_pkg::A_ARG) d.arg = pwdata[15:0];
      if (paddr == sbcm_pkg::A_CFG) d.cfg = pwdata[7:0];
    end
    // Sequencer
    unique case (q.st)
      S_IDLE: begin
        if (done && pwrite && paddr == sbcm_pkg::A_CMD) begin
          d.op   = pwdata[2:0];
          d.step = 4'd0;
          d.st   = S_SEND;
        end
      end
      S_SEND: begin
        unique case (s.kind)
          K_WR: begin
            d.wr   = 1'b1;
            d.rs   = s.rs;
            d.wd   = s.data;
            d.cnt  = wait_fn(s.wsel);
            d.step = q.step + 4'd1;
            d.st   = S_WAIT;
            if (q.op == sbcm_pkg::OP_DONE && s.rs) d.col8 = q.cfg[sbcm_pkg::CFG_COL8];
          end
          K_SKIP:  d.step = q.step + 4'd1;
          default: d.st = S_IDLE;
        endcase
      end
      S_WAIT: begin
        // Hold off the next word until the settle time has run out
        if (q.cnt <= 32'h0000_0001) d.st = S_SEND;
        else d.cnt = q.cnt - 32'h0000_0001;
      end
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{st: S_IDLE, op: 3'h0, step: 4'h0, cnt: 32'h0, arg: 16'h0, cfg: 8'h00, col8: 1'b0,
             rdy: 1'b0, err: 1'b0, rdata: 32'h0, wr: 1'b0, rs: 1'b0, wd: 16'h0000};
    end else begin
      q <= d;
    end
  end

  assign prdata  = q.rdata;
  assign pready  = q.rdy;
  assign pslverr = q.err;
  assign link.wr = q.wr;
  assign link.rs = q.rs;
  assign link.wd = q.wd;
endmodule
`default_nettype wire

// ==== test/sbcm_props.sv ====
// Purpose: Assertions on the link between host end and device end, and on device outputs.
// Assumes: One clock domain; presetn asynchronous, active low.
// Notes:   The index pointer is shadowed here so data words can be decoded.
`timescale 1ns/1ns
`default_nettype none
module sbcm_props #(
  parameter int COLS = 4,
  parameter int ROWS = 2
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        wr,
  input wire logic        rs,
  input wire logic [15:0] wd,
  input wire logic [1:0]  src_level,
  input wire logic [15:0] pix_out,
  input wire logic        gate_all_on,
  input wire logic        osc_amp_on,
  input wire logic        color8,
  input wire logic        partial,
  input wire logic        power_mode,
  input wire logic        gate_reg_en,
  input wire logic        pic_reg_en,
  input wire logic        dcdc_en
);
  // A frame drains in at most one scan of the panel, plus pipeline slack
  localparam int DRAIN_MAX = COLS * ROWS + 3;
  logic [6:0] idx_q;
  logic [6:0] idx_d;
  // ==========================================================================
  // Index shadow
  // Data words only mean something against the last index word
  always_comb begin
    idx_d = idx_q;
    if (wr && !rs) begin
      idx_d = wd[6:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_q <= 7'h00;
    end else begin
      idx_q <= idx_d;
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence ctl_wr;
    wr && rs && idx_q == sbcm_pkg::IDX_CTL;
  endsequence
  sequence standby_request_wr;
    ctl_wr ##0 wd[3];
  endsequence
  sequence run_wr;
    ctl_wr ##0 !wd[3];
  endsequence
  a_wr_pulse: assert property (wr |=> !wr)
    else $error("link strobe longer than one cycle");
  a_pwr_bits: assert property (wr && rs && idx_q == sbcm_pkg::IDX_PWR |=>
    {gate_reg_en, pic_reg_en, dcdc_en} == $past(wd[2:0]))
    else $error("power enables differ from written word");
  a_ctl_bits: assert property (ctl_wr |=>
    color8 == $past(wd[2]) && partial == $past(wd[4]) && power_mode == $past(wd[1]))
    else $error("control outputs differ from written word");
  a_standby_request_ground: assert property (standby_request_wr |-> ##2 src_level == 2'h3)
    else $error("standby did not ground sources");
  a_drain_bound: assert property (standby_request_wr |-> ##[1:DRAIN_MAX] (gate_all_on && !osc_amp_on))
    else $error("standby halt not reached within a frame");
  a_halt_ground: assert property (gate_all_on |-> src_level == 2'h3 && pix_out == 16'h0000)
    else $error("halted device not at ground");
  a_release_run: assert property (run_wr |-> ##2 (osc_amp_on && !gate_all_on))
    else $error("standby clear did not resume");
  a_override_lvl: assert property (run_wr |-> ##2
    src_level == ($past(wd[7], 2) ? 2'h1 : $past(wd[6], 2) ? 2'h2 : 2'h0))
    else $error("override level wrong");
  a_level_pixels: assert property (src_level != 2'h0 |->
    pix_out == ((src_level == 2'h1) ? 16'hFFFF : 16'h0000))
    else $error("forced level pixel wrong");
  a_col8_dots: assert property (color8 && $past(color8) && src_level == 2'h0 |->
    pix_out[15:11] == {5{pix_out[15]}} && pix_out[10:5] == {6{pix_out[10]}} && pix_out[4:0] == {5{pix_out[4]}})
    else $error("eight colour pixel not rail to rail");
endmodule
`default_nettype wire

// ==== test/standby_and_color_mode_ctrl_tb_top.sv ====
// Purpose: Self-checking bench: APB into the host end, device end behind the link.
// Assumes: Shortened supply waits and a 4 x 2 panel, so a frame is eight pixels.
// Notes:   Each APB transfer leaves a note in a queue; a monitor pops and compares.
`timescale 1ns/1ns
`default_nettype none
module standby_and_color_mode_ctrl_tb_top;
  typedef struct packed {
    logic        dchk;
    logic        perr;
    logic [31:0] d;
  } note_t;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  src_level;
  logic [15:0] pix_out;
  logic        gate_all_on, osc_amp_on, color8, partial, power_mode, gate_reg_en, pic_reg_en, dcdc_en;
  logic [2:0]  en_q;
  logic [6:0]  last_idx;
  logic [15:0] pix_mem [8];
  logic [31:0] rd;
  logic [7:0]  cv;
  logic        hit;
  note_t       notes [$];
  note_t       nt;
  bit          watch;
  int          err_total, n_checks, seed, cyc, hold_cyc;
  wire logic [9:0] dev_st = {src_level, gate_all_on, osc_amp_on, color8, partial, power_mode, en_q};
  // ==========================================================================
  // Design, link and checker
  sbcm_link_if sbcm_link_if_i ();
  sbcm_host #(.DCDC_WAIT(20), .REG_WAIT(10), .GATE_WAIT(5)) sbcm_host_i (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link(sbcm_link_if_i.host));
  sbcm_dev #(.COLS(4), .ROWS(2)) sbcm_dev_i (.pclk, .presetn, .link(sbcm_link_if_i.dev), .src_level, .pix_out,
    .gate_all_on, .osc_amp_on, .color8, .partial, .power_mode, .gate_reg_en, .pic_reg_en, .dcdc_en);
  sbcm_props sbcm_props_i (.pclk, .presetn, .wr(sbcm_link_if_i.wr), .rs(sbcm_link_if_i.rs),
    .wd(sbcm_link_if_i.wd), .src_level, .pix_out, .gate_all_on, .osc_amp_on, .color8, .partial, .power_mode,
    .gate_reg_en, .pic_reg_en, .dcdc_en);
  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One APB transfer; the note is queued before the request so the monitor never races it
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic dchk, input logic [31:0] e);
    notes.push_back({dchk, !(a inside {sbcm_pkg::A_CMD, sbcm_pkg::A_ARG, sbcm_pkg::A_CFG, sbcm_pkg::A_STAT}), e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Argument, opcode, then poll busy; a few edges let the device pipeline settle
  task automatic cmd(input logic [2:0] op, input logic [15:0] arg);
    apb(sbcm_pkg::A_ARG, 1'b1, {16'h0000, arg}, 1'b0, 32'h0);
    apb(sbcm_pkg::A_CMD, 1'b1, {29'h0, op}, 1'b0, 32'h0);
    rd = 32'h1;
    while (rd[0] !== 1'b0) apb(sbcm_pkg::A_STAT, 1'b0, 32'h0, 1'b0, 32'h0);
    repeat (3) @(posedge pclk);
  endtask
  // ==========================================================================
  // Monitor: timeout, APB answers, link index, supply bring-up spacing
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      final_report();
    end
    if (sbcm_link_if_i.wr === 1'b1 && sbcm_link_if_i.rs === 1'b0) begin
      last_idx = sbcm_link_if_i.wd[6:0];
    end
    if (psel && penable && pready === 1'b1) begin
      nt = notes.pop_front();
      chk(32'(pslverr), 32'(nt.perr));
      if (nt.dchk) begin
        chk(prdata, nt.d);
      end
    end
    if ({gate_reg_en, pic_reg_en, dcdc_en} !== en_q) begin
      if (watch && pic_reg_en && !en_q[1]) chk(32'({en_q, hold_cyc >= 20, src_level}), 32'hD);
      if (watch && gate_reg_en && !en_q[2]) chk(32'({en_q, hold_cyc >= 10, src_level}), 32'h1D);
      hold_cyc = 0;
    end else begin
      hold_cyc++;
    end
    en_q = {gate_reg_en, pic_reg_en, dcdc_en};
  end
  // ==========================================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, presetn, paddr, pwdata} = '0;
    {err_total, n_checks, cyc, hold_cyc, watch, en_q} = '0;
    seed = 59;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(32'(dev_st), 32'h040);
    apb(8'h10, 1'b1, 32'hFFFF_FFFF, 1'b0, 32'h0);
    apb(8'h10, 1'b0, 32'h0, 1'b1, 32'h0);
    // Raw control words, standby bit clear, colour bit clear after the first; first word sets both overrides and colour
    for (int i = 0; i < 6; i++) begin
      cv = (i == 0) ? 8'hC6 : 8'($random(seed)) & 8'hF3;
      cmd(sbcm_pkg::OP_IDX, 16'(sbcm_pkg::IDX_CTL));
      chk(32'(last_idx), 32'(sbcm_pkg::IDX_CTL));
      cmd(sbcm_pkg::OP_DATA, {8'h00, cv});
      chk(32'(dev_st), 32'({cv[7] ? 2'h1 : cv[6] ? 2'h2 : 2'h0, 2'b01, cv[2], cv[4], cv[1], 3'b000}));
    end
    cmd(sbcm_pkg::OP_DATA, 16'h0000);
    // Every supply enable code, random application bits alongside
    cmd(sbcm_pkg::OP_IDX, 16'(sbcm_pkg::IDX_PWR));
    for (int i = 0; i < 8; i++) begin
      cv = {1'b0, 4'($random(seed)), 3'(i)};
      cmd(sbcm_pkg::OP_DATA, {8'h00, cv});
      chk(32'(dev_st[2:0]), 32'(i));
    end
    // Standby entry (plain, then gate step skipped); a command while busy is dropped
    for (int j = 0; j < 2; j++) begin
      cv = (j == 0) ? 8'h05 : 8'h60;
      apb(sbcm_pkg::A_CFG, 1'b1, {24'h0, cv}, 1'b0, 32'h0);
      apb(sbcm_pkg::A_CMD, 1'b1, {29'h0, sbcm_pkg::OP_SON}, 1'b0, 32'h0);
      cmd(sbcm_pkg::OP_SOFF, 16'h0000);
      chk(32'(dev_st), 32'({2'h3, 2'b10, 2'b00, cv[6], cv[5], 2'b11}));
      cmd(sbcm_pkg::OP_IDX, 16'(sbcm_pkg::IDX_CTL));
      cmd(sbcm_pkg::OP_DATA, 16'h0088);
      chk(32'(dev_st), 32'({2'h3, 2'b10, 3'b000, cv[5], 2'b11}));
      watch = 1'b1;
      apb(sbcm_pkg::A_CFG, 1'b1, {24'h0, cv & 8'hDF}, 1'b0, 32'h0);
      cmd(sbcm_pkg::OP_SOFF, 16'h0000);
      watch = 1'b0;
      chk(32'(dev_st), 32'({2'h0, 2'b01, 2'b00, cv[6], 3'b111}));
      cmd(sbcm_pkg::OP_DONE, 16'h0000);
      chk(32'(dev_st), 32'({2'h0, 2'b01, 2'b00, cv[6], 3'b111}));
    end
    // Into eight colour, then back: blank, rewrite a whole frame, display on
    for (int c = 1; c >= 0; c--) begin
      apb(sbcm_pkg::A_CFG, 1'b1, 32'(c) << 7, 1'b0, 32'h0);
      cmd(sbcm_pkg::OP_BLANK, 16'h0000);
      chk(32'(last_idx), 32'(sbcm_pkg::IDX_PIX));
      chk({14'h0, src_level, pix_out}, 32'h0002_0000);
      for (int k = 0; k < 8; k++) begin
        pix_mem[k] = 16'($random(seed));
        cmd(sbcm_pkg::OP_DATA, pix_mem[k]);
      end
      cmd(sbcm_pkg::OP_DONE, 16'h0000);
      apb(sbcm_pkg::A_CMD, 1'b0, 32'h0, 1'b1, 32'(sbcm_pkg::OP_DONE));
      chk(32'({color8, src_level}), 32'({c[0], 2'h0}));
      repeat (16) begin
        @(posedge pclk);
        hit = 1'b0;
        foreach (pix_mem[k]) hit |= pix_out === (c[0] ? {{5{pix_mem[k][15]}}, {6{pix_mem[k][10]}},
          {5{pix_mem[k][4]}}} : pix_mem[k]);
        chk(32'(hit), 32'h1);
      end
    end
    final_report();
  end
endmodule
`default_nettype wire
